// >>> shared/adcsr_map.svh
// constants for the adc serial readout block
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH
`define ADCSR_CLK_NS 50
`define ADCSR_INT_HALF 5
`define ADCSR_SETUP_NS 30
`define ADCSR_SETUP_CYC ((`ADCSR_SETUP_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS)
`define ADCSR_EDGES_SHORT 19
`define ADCSR_EDGES_LONG 20
`define ADCSR_WORD_BITS 16
`define ADCSR_RES_BITS 14
`define ADCSR_CODE_POS_MAX 14'h1FFF
`define ADCSR_CODE_NEG_MAX 14'h2000
`define ADCSR_CODE_MINUS1 14'h3FFF
`define ADCSR_CODE_ZERO 14'h0000
`endif

// >>> shared/adcsr_pkg.sv
// types for the adc serial readout block
package adcsr_pkg;
  typedef enum logic [1:0] {
    ADCSR_IDLE = 2'b00,
    ADCSR_CONV = 2'b01,
    ADCSR_DONE = 2'b11
  } adcsr_state_e;
  typedef struct packed {
    logic frame_oe;
    logic sclk_oe;
    logic data_oe;
  } adcsr_od_s;
endpackage : adcsr_pkg

// >>> core/adcsr_sync.sv
// two-flop synchroniser with rising and falling edge detect
`timescale 1ns/1ps
module adcsr_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign q = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule : adcsr_sync

// >>> core/adcsr_readout.sv
// conversion control and serial readout of the 14-bit converter
//
// Behaviour
// - conversion takes 19 or 20 clock rises
// - start near a rise gives 20 rises
// - gated internal clock: always 19 rises
// - start rising edge: hold and convert
// - bits shift out during conversion
// - word: two zeros then 14 bits msb first
// - data changes on serial clock rise
// - frame low at start, first bit valid
// - frame, clock, data are open drain
// - serial clock derived from converter clock
// - clock mode: gated off or continuous
// - codes two's complement, lsb fs/16384
// - 1FFF top, 2000 bottom, 3FFF minus one
// - dac output updates on load fall
// - start accepted asynchronously to clock
// - use_internal_osc high selects internal oscillator
`timescale 1ns/1ps
`include "adcsr_map.svh"
module adcsr_readout
  import adcsr_pkg::*;
#(
  parameter int INT_HALF = `ADCSR_INT_HALF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic conversion_start_n,
  input wire logic ext_clk,
  input wire logic use_internal_osc,
  input wire logic clock_continuous,
  input wire logic dac_load_n,
  input wire logic [13:0] sample_code,
  input wire logic [13:0] dac_code,
  output logic receive_frame_n_o,
  output logic receive_frame_n_oe,
  output logic receive_clk_o,
  output logic receive_clk_oe,
  output logic receive_data_out_o,
  output logic receive_data_out_oe,
  output logic [13:0] dac_value,
  output logic converting,
  output logic track_hold
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic start_rise;
  logic ext_rise;
  logic ext_fall;
  logic load_fall;
  logic sel_int;
  logic cont;
  logic int_osc_r;
  logic [7:0] osc_cnt_r;
  logic int_rise;
  logic int_fall;
  logic mclk;
  logic mclk_rise;
  logic mclk_fall;
  // start accepted with no relation to the converter clock
  adcsr_sync u_start (.core_clk(core_clk), .rst_n(rst_n),
    .d(conversion_start_n), .q(), .rise(start_rise), .fall());
  // pin inverted so the high reset level of the synchroniser matches the
  // low idle clock and no false edge follows reset
  adcsr_sync u_ext (.core_clk(core_clk), .rst_n(rst_n),
    .d(~ext_clk), .q(), .rise(ext_fall), .fall(ext_rise));
  adcsr_sync u_load (.core_clk(core_clk), .rst_n(rst_n),
    .d(dac_load_n), .q(), .rise(), .fall(load_fall));
  adcsr_sync u_sel (.core_clk(core_clk), .rst_n(rst_n),
    .d(use_internal_osc), .q(sel_int), .rise(), .fall());
  adcsr_sync u_cont (.core_clk(core_clk), .rst_n(rst_n),
    .d(clock_continuous), .q(cont), .rise(), .fall());
  // ------------------------------------------------------------
  // converter master clock
  // ------------------------------------------------------------
  logic osc_run;
  adcsr_state_e state_r;
  // gated internal oscillator stops outside a conversion
  assign osc_run = cont | (state_r == ADCSR_CONV);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= 8'h00;
      int_osc_r <= 1'b0;
    end else if (!osc_run && !int_osc_r) begin
      osc_cnt_r <= 8'h00;
    end else if (osc_cnt_r == 8'(INT_HALF - 1)) begin
      osc_cnt_r <= 8'h00;
      int_osc_r <= ~int_osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end
  assign int_rise = osc_run && !int_osc_r && osc_cnt_r == 8'(INT_HALF - 1);
  assign int_fall = int_osc_r && osc_cnt_r == 8'(INT_HALF - 1);
  assign mclk = sel_int ? int_osc_r : 1'b0;
  assign mclk_rise = sel_int ? int_rise : ext_rise;
  assign mclk_fall = sel_int ? int_fall : ext_fall;
  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  logic [4:0] edges_r;
  logic [4:0] target_r;
  logic [4:0] bits_r;
  logic [15:0] shift_r;
  logic [3:0] since_start_r;
  logic near_edge;
  // a start seen just before a rise costs one more edge
  assign near_edge = !(sel_int && !cont) && (since_start_r <
    4'(`ADCSR_SETUP_CYC)) && mclk_rise;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ADCSR_IDLE;
      edges_r <= 5'h00;
      target_r <= 5'(`ADCSR_EDGES_SHORT);
      since_start_r <= 4'hF;
    end else begin
      if (since_start_r != 4'hF) begin
        since_start_r <= since_start_r + 4'h1;
      end
      case (state_r)
        ADCSR_IDLE: begin
          if (start_rise) begin
            state_r <= ADCSR_CONV;
            edges_r <= 5'h00;
            since_start_r <= 4'h0;
            target_r <= 5'(`ADCSR_EDGES_SHORT);
          end
        end
        ADCSR_CONV: begin
          if (near_edge && edges_r == 5'h00) begin
            target_r <= 5'(`ADCSR_EDGES_LONG);
          end
          if (mclk_rise) begin
            edges_r <= edges_r + 5'h01;
            if (edges_r + 5'h01 == target_r) begin
              state_r <= ADCSR_DONE;
            end
          end
        end
        ADCSR_DONE: begin
          state_r <= ADCSR_IDLE;
        end
        default: begin
          state_r <= ADCSR_IDLE;
        end
      endcase
    end
  end
  assign converting = (state_r == ADCSR_CONV);
  assign track_hold = converting;
  // ------------------------------------------------------------
  // serial word: shifted on rises while converting
  // ------------------------------------------------------------
  logic frame_r;
  logic data_r;
  logic sclk_en_r;
  logic frame_q_r;
  logic line_low_r;
  logic fall_seen_r;
  logic shift_ok;
  // a rise with no receiver fall behind it must not move the data,
  // or the first leading zero would never be sampled
  assign shift_ok = frame_r && mclk_rise && fall_seen_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 16'h0000;
      bits_r <= 5'h00;
      frame_r <= 1'b0;
      data_r <= 1'b1;
    end else if (state_r == ADCSR_IDLE && start_rise) begin
      // two leading zeros, then the twos complement code
      shift_r <= {2'b00, sample_code};
      bits_r <= 5'h00;
      frame_r <= 1'b1;
      data_r <= 1'b0;
    end else if (shift_ok) begin
      if (bits_r == 5'(`ADCSR_WORD_BITS - 1)) begin
        frame_r <= 1'b0;
        data_r <= 1'b1;
      end else begin
        data_r <= shift_r[14];
        shift_r <= {shift_r[14:0], 1'b0};
      end
      bits_r <= bits_r + 5'h01;
    end
  end
  // a line fall counts only if the frame was already low before it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q_r <= 1'b0;
      line_low_r <= 1'b0;
      fall_seen_r <= 1'b0;
    end else begin
      frame_q_r <= frame_r;
      line_low_r <= receive_clk_oe;
      if (state_r == ADCSR_IDLE && start_rise) begin
        fall_seen_r <= 1'b0;
      end else if (frame_q_r && receive_clk_oe && !line_low_r) begin
        fall_seen_r <= 1'b1;
      end
    end
  end
  // serial clock follows the converter clock, gated in noncontinuous mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_en_r <= 1'b0;
    end else if (cont || frame_r || converting) begin
      sclk_en_r <= 1'b1;
    end else if (mclk_fall || !sel_int) begin
      sclk_en_r <= 1'b0;
    end
  end
  logic sclk_lvl;
  logic ext_lvl_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_lvl_r <= 1'b0;
    end else if (mclk_rise) begin
      ext_lvl_r <= 1'b1;
    end else if (mclk_fall) begin
      ext_lvl_r <= 1'b0;
    end
  end
  assign sclk_lvl = sel_int ? mclk : ext_lvl_r;
  // open drain: only pull low, never drive high
  assign receive_frame_n_o = 1'b0;
  assign receive_frame_n_oe = frame_r;
  assign receive_clk_o = 1'b0;
  assign receive_clk_oe = sclk_en_r & ~sclk_lvl;
  assign receive_data_out_o = 1'b0;
  assign receive_data_out_oe = frame_r & ~data_r;
  // ------------------------------------------------------------
  // dac latch
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_value <= `ADCSR_CODE_ZERO;
    end else if (load_fall) begin
      dac_value <= dac_code;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start;
    state_r == ADCSR_IDLE && start_rise;
  endsequence
  a_start_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_start |=> frame_r && converting)
    else $error("frame not asserted after start");
  a_start_convert: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_start |=> state_r == ADCSR_CONV)
    else $error("conversion did not begin");
  a_edge_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    converting && mclk_rise && edges_r == 5'd19 |=> !converting)
    else $error("conversion exceeded twenty edges");
  a_gated_short: assert property (@(posedge core_clk) disable iff (!rst_n)
    converting && sel_int && !cont |-> target_r == 5'd19)
    else $error("gated mode not nineteen edges");
  a_long_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    converting && near_edge && edges_r == 5'h00 |=> target_r == 5'd20)
    else $error("late start not lengthened");
  a_od_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    !receive_frame_n_o && !receive_clk_o && !receive_data_out_o)
    else $error("open drain driven high");
  a_frame_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    shift_ok && bits_r == 5'd15 |=> !frame_r)
    else $error("frame not released after sixteen bits");
  a_lead_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_start |=> receive_data_out_oe ##0 !data_r)
    else $error("first bit not zero");
  a_data_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    frame_r && !mclk_rise && !start_rise |=> $stable(data_r))
    else $error("data changed off a clock rise");
  a_dac_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    load_fall |=> dac_value == $past(dac_code))
    else $error("dac not updated on load fall");
  a_sclk_cont: assert property (@(posedge core_clk) disable iff (!rst_n)
    cont ##1 cont |-> sclk_en_r)
    else $error("continuous clock gated off");
endmodule : adcsr_readout

// >>> dv/adcsr_rx_model.sv
// receiving serial port with the pull-ups of the open-drain lines
`timescale 1ns/1ps
module adcsr_rx_model (
  input wire logic frame_oe,
  input wire logic clk_oe,
  input wire logic data_oe,
  output logic frame_n,
  output logic sclk,
  output logic data,
  output logic [15:0] word,
  output logic [5:0] nbits
);
  time t_frame = 0;
  // a released line is pulled high, never left at its last level
  assign frame_n = !frame_oe;
  assign sclk = !clk_oe;
  assign data = !data_oe;
  initial begin
    word = 16'h0000;
    nbits = 6'h00;
  end
  // a clock fall in the same step as the frame fall carries no bit
  always @(negedge frame_n) begin
    nbits = 6'h00;
    t_frame = $time;
  end
  always @(negedge sclk) begin
    if (!frame_n && $time > t_frame) begin
      word = {word[14:0], data};
      nbits = nbits + 6'h01;
    end
  end
endmodule : adcsr_rx_model

// >>> dv/test_adc_serial_readout.sv
// self-checking bench of the adc serial readout block
`timescale 1ns/1ps
module test_adc_serial_readout;
  logic core_clk = 1'b0, ext_clk = 1'b0, rst_n = 1'b0;
  logic conversion_start_n = 1'b1, dac_load_n = 1'b1;
  logic use_internal_osc = 1'b0, clock_continuous = 1'b1;
  logic [13:0] sample_code = 14'h0000, dac_code = 14'h0000, dac_value;
  logic frame_oe, clk_oe, data_oe, converting, track_hold;
  logic frame_n, sclk, data;
  logic [15:0] word, exp_w;
  logic [5:0] nbits;
  logic [31:0] seed = 32'h9484;
  logic [15:0] exp_q[$];
  int miscompares = 0, n_compared = 0, n_ext = 0, n_sck = 0;
  always #25 core_clk = ~core_clk;
  // converter clock rises at 37 ns modulo 400 ns, unrelated to core_clk
  initial begin
    #37;
    forever begin
      ext_clk = 1'b1;
      #200 ext_clk = 1'b0;
      #200;
    end
  end
  always @(posedge ext_clk) n_ext++;
  always @(posedge sclk) n_sck++;
  adcsr_readout dut (.core_clk(core_clk), .rst_n(rst_n),
    .conversion_start_n(conversion_start_n), .ext_clk(ext_clk),
    .use_internal_osc(use_internal_osc),
    .clock_continuous(clock_continuous), .dac_load_n(dac_load_n),
    .sample_code(sample_code), .dac_code(dac_code),
    .receive_frame_n_o(), .receive_frame_n_oe(frame_oe),
    .receive_clk_o(), .receive_clk_oe(clk_oe),
    .receive_data_out_o(), .receive_data_out_oe(data_oe),
    .dac_value(dac_value), .converting(converting),
    .track_hold(track_hold));
  adcsr_rx_model rx (.frame_oe(frame_oe), .clk_oe(clk_oe),
    .data_oe(data_oe), .frame_n(frame_n), .sclk(sclk), .data(data),
    .word(word), .nbits(nbits));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge frame_n) begin
    if (rst_n === 1'b1) begin
      #1;
      chk(exp_q.size() > 0, "frame without a start");
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
        chk(word === exp_w && nbits === 6'd16, "serial word");
        chk(converting === 1'b1, "word not sent during conversion");
      end
    end
  end
  // ph >= 0 puts the start edge at that time modulo 400 ns
  task automatic convert(input logic [13:0] code, input int ph,
      input int lo, input int hi);
    int k, n;
    sample_code = code;
    conversion_start_n = 1'b0;
    @(negedge core_clk);
    while (ph >= 0 && ($time % 400) != ph) @(negedge core_clk);
    exp_q.push_back({2'b00, code});
    n_ext = 0;
    n_sck = 0;
    conversion_start_n = 1'b1;
    k = 0;
    while (frame_oe !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    chk(frame_oe === 1'b1 && data_oe === 1'b1, "frame start");
    chk(track_hold === 1'b1 && converting === 1'b1, "hold");
    seed = lfsr(seed);
    sample_code = seed[13:0];
    while (converting === 1'b1 && k < 600) begin
      @(negedge core_clk);
      k++;
    end
    n = use_internal_osc ? n_sck : n_ext;
    chk(n >= lo && n <= hi, "conversion length");
    // acquisition time above 2 us before the next start
    repeat (45) @(negedge core_clk);
  endtask : convert
  task automatic clock_after(input int lo, input int hi);
    n_sck = 0;
    repeat (40) @(negedge core_clk);
    chk(n_sck >= lo && n_sck <= hi, "serial clock between words");
  endtask : clock_after
  initial begin
    #600_000;
    miscompares++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    convert(14'h1FFF, 200, 19, 19);
    convert(14'h2000, 200, 19, 19);
    convert(14'h0000, 200, 19, 19);
    convert(14'h3FFF, 0, 20, 20);
    clock_after(4, 6);
    use_internal_osc = 1'b1;
    clock_continuous = 1'b0;
    // let the mode straps settle through their synchronisers
    repeat (8) @(negedge core_clk);
    convert(seed[13:0], -1, 19, 19);
    clock_after(0, 0);
    repeat (6) begin
      seed = lfsr(seed);
      use_internal_osc = seed[20];
      clock_continuous = 1'b1;
      repeat (8) @(negedge core_clk);
      convert(seed[13:0], -1, 19, 20);
    end
    repeat (3) begin
      seed = lfsr(seed);
      dac_code = seed[13:0] ^ ~dac_value;
      repeat (6) @(negedge core_clk);
      chk(dac_value !== dac_code, "dac moved without load");
      dac_load_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk(dac_value === dac_code, "dac load");
      dac_load_n = 1'b1;
      @(negedge core_clk);
    end
    chk(exp_q.size() == 0, "missing serial word");
    give_verdict();
  end
endmodule : test_adc_serial_readout
